// file: adcw_control_word_decoder.sv
// Purpose: Serial configuration word decoder, channel sequencer and result tagging of an eight-input converter.
// Assumes: Converter core and temperature sensor sit outside and answer with valid pulses.
// Notes: Link logic runs on sclk; cs_n high clears its counters, event levels and dout asynchronously to constants, but not shift_reg.
`default_nettype none
`include "adcw_defines.svh"

module adcw_control_word_decoder
    import adcw_pkg::*;
(
    input wire logic clk_sys, // System clock, 25 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic sclk, // Serial clock from the host
    input wire logic cs_n, // Chip select, active low
    input wire logic din, // Serial data in
    output var logic dout, // Serial data out
    input wire logic [11:0] adc_result, // Converter result
    input wire logic adc_result_valid, // Converter result pulse
    input wire logic [11:0] temp_result, // Temperature sensor result
    input wire logic temp_done, // Temperature result pulse
    output var logic conv_start, // Start converting mux_sel
    output var logic [2:0] mux_sel, // Input multiplexer channel
    output var logic temp_start, // Start temperature conversion
    output var logic temp_busy, // Temperature conversion running
    output var logic outside_reference_select_sel, // Outside reference chosen
    output var logic partial_sleep // Partial power-down active
);
    // Lowest set bit of a channel mask
    function automatic logic [2:0] lowest_chan(input logic [0:7] mask);
        logic [2:0] pick;
        pick = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (mask[i]) begin
                pick = 3'(i);
            end
        end
        return pick;
    endfunction

    // Link domain
    logic [4:0] fall_cnt_reg;
    logic [4:0] rise_cnt_reg;
    logic [15:0] shift_reg;
    logic word_done_reg;
    logic mux_done_reg;

    // System domain
    logic [2:0] sync_raw;
    logic [2:0] sync_lvl;
    logic cs_s;
    logic word_s;
    logic mux_s;
    logic cs_d_reg;
    logic word_d_reg;
    logic mux_d_reg;
    logic frame_start;
    logic frame_end;
    logic word_evt;
    logic mux_evt;
    logic write_evt;
    adcw_cfg_t cfg_reg;
    adcw_cfg_t cfg_next;
    logic [0:7] seq_left_reg;
    logic temp_pend_reg;
    logic [3:0] conv_tag_reg;
    adcw_result_t res_reg;
    logic res_pend_reg;
    logic [15:0] tx_word_reg;
    logic consume;
    logic avg_restart;
    logic avg_valid;
    logic [11:0] avg_value;

    // Event order inside a frame relies on the mux edge coming before the last word edge
    if (`ADCW_MUX_EDGE >= `ADCW_FRAME_EDGES) begin : g_bad_edges
        $error("adcw_control_word_decoder needs the mux edge before the last word edge");
    end

    if (`ADCW_WRITE_BIT != `ADCW_WORD_BITS - 1) begin : g_bad_write_bit
        $error("adcw_control_word_decoder needs the write bit at the top of the word");
    end

    if ($bits(adcw_cfg_t) != `ADCW_WORD_BITS - 1) begin : g_bad_cfg_width
        $error("adcw_control_word_decoder needs fifteen configuration bits");
    end

    // Falling edges: edge count and event levels, cleared whenever cs_n is high
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            fall_cnt_reg <= 5'h00;
            word_done_reg <= 1'b0;
            mux_done_reg <= 1'b0;
        end else if (fall_cnt_reg != `ADCW_FRAME_EDGES) begin
            fall_cnt_reg <= fall_cnt_reg + 5'h01;
            if (fall_cnt_reg == `ADCW_MUX_EDGE - 5'h01) begin
                mux_done_reg <= 1'b1;
            end
            if (fall_cnt_reg == `ADCW_FRAME_EDGES - 5'h01) begin
                word_done_reg <= 1'b1;
            end
        end
    end

    // Shifting stops after sixteen edges, so the word stays put for the system side
    always_ff @(negedge sclk) begin
        if (!cs_n && fall_cnt_reg != `ADCW_FRAME_EDGES) begin
            shift_reg <= {shift_reg[14:0], din};
        end
    end

    // Rising edges: result out MSB first, ones outside the frame
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rise_cnt_reg <= 5'h00;
            dout <= 1'b1;
        end else if (rise_cnt_reg != `ADCW_FRAME_EDGES) begin
            rise_cnt_reg <= rise_cnt_reg + 5'h01;
            dout <= tx_word_reg[`ADCW_LAST_BIT_IDX - rise_cnt_reg[3:0]];
        end else begin
            dout <= 1'b1;
        end
    end

    assign sync_raw = {cs_n, word_done_reg, mux_done_reg};

    adcw_sync #(
        .WIDTH(3),
        .RESET_VALUE(3'b100)
    ) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in(sync_raw),
        .sync_out(sync_lvl)
    );

    assign cs_s = sync_lvl[2];
    assign word_s = sync_lvl[1];
    assign mux_s = sync_lvl[0];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cs_d_reg <= 1'b1;
            word_d_reg <= 1'b0;
            mux_d_reg <= 1'b0;
        end else begin
            cs_d_reg <= cs_s;
            word_d_reg <= word_s;
            mux_d_reg <= mux_s;
        end
    end

    // Edge detectors reset to the idle levels, so no false frame follows reset
    assign frame_start = cs_d_reg && !cs_s;
    assign frame_end = !cs_d_reg && cs_s;
    assign word_evt = word_s && !word_d_reg;
    assign mux_evt = mux_s && !mux_d_reg;
    assign write_evt = word_evt && shift_reg[`ADCW_WRITE_BIT];

    // shift_reg crosses without synchronisers: it is frozen from the sixteenth falling edge
    // until the next frame, and word_evt comes two stages after that edge
    always_comb begin
        cfg_next = adcw_cfg_t'(shift_reg[14:0]);
        cfg_next.ignored_bits = 2'b00;
    end

    // Configuration holds through sleep; only a qualified write changes it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg_reg <= adcw_cfg_t'(`ADCW_CFG_RESET);
        end else if (write_evt) begin
            cfg_reg <= cfg_next;
        end
    end

    assign outside_reference_select_sel = cfg_reg.outside_reference_select;

    // Sleep is entered and left at the end of the frame that wrote the bit
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            partial_sleep <= 1'b0;
        end else if (frame_end) begin
            partial_sleep <= cfg_reg.partial_sleep;
        end
    end

    // Sequencer
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            seq_left_reg <= 8'h00;
            temp_pend_reg <= 1'b0;
            mux_sel <= 3'h0;
            conv_tag_reg <= 4'h0;
            conv_start <= 1'b0;
            temp_start <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            temp_start <= 1'b0;
            if (write_evt) begin
                seq_left_reg <= cfg_next.input_select_bits;
                temp_pend_reg <= cfg_next.temp_request;
                mux_sel <= lowest_chan(cfg_next.input_select_bits);
            end else if (frame_start && !partial_sleep) begin
                if (seq_left_reg != 8'h00) begin
                    conv_start <= 1'b1;
                    conv_tag_reg <= {1'b0, mux_sel};
                    seq_left_reg[mux_sel] <= 1'b0;
                // A pending temperature waits for the channels and for any running temperature conversion
                end else if (temp_pend_reg && !temp_busy) begin
                    temp_start <= 1'b1;
                    temp_pend_reg <= 1'b0;
                end
            end else if (mux_evt) begin
                if (seq_left_reg != 8'h00) begin
                    mux_sel <= lowest_chan(seq_left_reg);
                end else if (cfg_reg.repeat_enable && !temp_pend_reg) begin
                    seq_left_reg <= cfg_reg.input_select_bits;
                    temp_pend_reg <= cfg_reg.temp_request;
                    mux_sel <= lowest_chan(cfg_reg.input_select_bits);
                end
            end
        end
    end

    // Busy clears only once the result is held, so the host's wait starts from a ready result
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            temp_busy <= 1'b0;
        end else if (temp_start) begin
            temp_busy <= 1'b1;
        end else if (avg_valid) begin
            temp_busy <= 1'b0;
        end
    end

    // Average starts over when the averaging bit flips or sleep is entered
    assign avg_restart = (write_evt && (cfg_next.temp_average_enable != cfg_reg.temp_average_enable))
                         || (frame_end && cfg_reg.partial_sleep && !partial_sleep);

    adcw_temp_avg #(
        .SHIFT(`ADCW_AVG_SHIFT)
    ) u_avg (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .restart(avg_restart),
        .avg_on(cfg_reg.temp_average_enable),
        .sample_valid(temp_done && temp_busy),
        .sample(temp_result),
        .result_valid(avg_valid),
        .result(avg_value)
    );

    // Consumption waits for cs_n high so the outgoing word never moves under the link
    assign consume = cs_s && !frame_end && res_pend_reg && !partial_sleep;

    // A new result wins over its consumption in the same cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            res_reg <= adcw_result_t'(`ADCW_IDLE_WORD);
            res_pend_reg <= 1'b0;
        end else if (adc_result_valid) begin
            res_reg <= '{tag: conv_tag_reg, data: adc_result};
            res_pend_reg <= 1'b1;
        end else if (avg_valid) begin
            res_reg.tag <= cfg_reg.temp_average_enable ? `ADCW_TAG_TEMP_AVG : `ADCW_TAG_TEMP;
            res_reg.data <= avg_value;
            res_pend_reg <= 1'b1;
        end else if (consume) begin
            res_pend_reg <= 1'b0;
        end
    end

    // Outgoing word changes only while cs_n is high, so the link side reads it as static
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_word_reg <= `ADCW_IDLE_WORD;
        end else if (frame_end || partial_sleep) begin
            tx_word_reg <= `ADCW_IDLE_WORD;
        end else if (consume) begin
            tx_word_reg <= res_reg;
        end
    end
endmodule // adcw_control_word_decoder

`default_nettype wire

// file: adcw_control_word_decoder_chk.sv
// Purpose: Port-level checks of the configuration word decoder.
// Assumes: Link inputs are looked at as sampled levels in the clk_sys domain.
// Notes: Bound to every decoder instance.
`default_nettype none

module adcw_control_word_decoder_chk (
    input wire logic clk_sys, // System clock
    input wire logic sys_rst, // Reset
    input wire logic cs_n, // Chip select
    input wire logic conv_start, // Conversion start
    input wire logic [2:0] mux_sel, // Channel
    input wire logic temp_start, // Temperature start
    input wire logic temp_busy, // Temperature busy
    input wire logic temp_done, // Temperature done
    input wire logic outside_reference_select_sel, // Reference select
    input wire logic partial_sleep // Power-down
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_busy_rise;
        temp_start |=> temp_busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy missing after start");
    property p_busy_hold;
        temp_busy && !temp_done && !$past(temp_done) |=> temp_busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    property p_busy_fall;
        temp_busy && temp_done |=> temp_busy ##1 !temp_busy;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy stuck after done");
    property p_tstart_idle;
        temp_start |-> !temp_busy ##1 !temp_start;
    endproperty
    a_tstart_idle: assert property (p_tstart_idle) else $error("temperature restarted");
    property p_start_gate;
        conv_start |-> !cs_n ##1 !conv_start;
    endproperty
    a_start_gate: assert property (p_start_gate) else $error("conversion start outside frame");
    // Four high samples mean no frame edge is still in the synchroniser
    property p_idle_quiet;
        cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) |-> !conv_start && !temp_start;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("start without frame");
    property p_sleep_quiet;
        partial_sleep |-> !conv_start && !temp_start;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("start while asleep");
    property p_sleep_edge;
        !$stable(partial_sleep) |-> cs_n;
    endproperty
    a_sleep_edge: assert property (p_sleep_edge) else $error("sleep changed inside frame");
    property p_ref_edge;
        !$stable(outside_reference_select_sel) |-> !cs_n;
    endproperty
    a_ref_edge: assert property (p_ref_edge) else $error("reference changed outside frame");
    property p_mux_hold;
        conv_start |=> $stable(mux_sel) [*4];
    endproperty
    a_mux_hold: assert property (p_mux_hold) else $error("mux moved during conversion");
    property p_mux_frame;
        !$stable(mux_sel) |-> !cs_n;
    endproperty
    a_mux_frame: assert property (p_mux_frame) else $error("mux moved between frames");
endmodule // adcw_control_word_decoder_chk

bind adcw_control_word_decoder adcw_control_word_decoder_chk u_chk (.clk_sys, .sys_rst, .cs_n, .conv_start,
    .mux_sel, .temp_start, .temp_busy, .temp_done, .outside_reference_select_sel, .partial_sleep);

`default_nettype wire

// file: adcw_defines.svh
// Purpose: Shared constants of the converter configuration word decoder.
// Assumes: Included by bare name from every design file that needs it.
// Notes: Definitions only.
`ifndef ADCW_DEFINES_SVH
`define ADCW_DEFINES_SVH

`define ADCW_CLK_HZ 25000000
`define ADCW_WORD_BITS 16
`define ADCW_WRITE_BIT 15
`define ADCW_MUX_EDGE 5'h0E
`define ADCW_FRAME_EDGES 5'h10
`define ADCW_LAST_BIT_IDX 4'hF
`define ADCW_IDLE_WORD 16'hFFFF
`define ADCW_CFG_RESET 15'h0000
`define ADCW_TAG_TEMP 4'h8
`define ADCW_TAG_TEMP_AVG 4'h9
`define ADCW_AVG_SHIFT 3
`define ADCW_TEMP_GAP_NS 100
`define ADCW_TEMP_GAP_CYC ((`ADCW_TEMP_GAP_NS * (`ADCW_CLK_HZ / 1000000) + 999) / 1000)

`endif

// file: adcw_host.sv
// Purpose: Serial host that frames one transfer per call.
// Assumes: 160 ns serial clock, idle low and stopped between frames.
// Notes: Start delays are off the clk_sys grid on purpose.
`default_nettype none

module adcw_host (
    output var logic sclk, // Serial clock
    output var logic cs_n, // Chip select
    output var logic din, // Data to the device
    input wire logic dout // Data from the device
);
    timeunit 1ns;
    timeprecision 1ps;
    // cs_n rises after time zero so the link side is cleared whatever order start-up runs in
    initial begin
        sclk = 1'h0;
        cs_n = 1'h0;
        din = 1'h0;
        #1;
        cs_n = 1'h1;
    end

    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'hFFFF;
        cs_n = 1'h0;
        #217;
        for (int i = 0; i < n; i++) begin
            sclk = 1'h1;
            din = (i < 16) ? w[15 - i] : 1'h1;
            #80;
            sclk = 1'h0;
            if (i < 16) begin
                r = {r[14:0], dout};
            end
            #80;
        end
        #220;
        cs_n = 1'h1;
        // Inverted so a design reading din outside frames is not lucky
        din = ~din;
        #260;
    endtask
endmodule // adcw_host

`default_nettype wire

// file: adcw_pkg.sv
// Purpose: Types of the converter configuration word decoder.
// Assumes: Nothing beyond the defines header.
// Notes: Field order of adcw_cfg_t matches the serial word from bit 14 down to bit 0.
`default_nettype none

package adcw_pkg;

    typedef struct packed {
        logic repeat_enable;
        logic [0:7] input_select_bits;
        logic temp_request;
        logic [1:0] ignored_bits;
        logic outside_reference_select;
        logic temp_average_enable;
        logic partial_sleep;
    } adcw_cfg_t;

    typedef struct packed {
        logic [3:0] tag;
        logic [11:0] data;
    } adcw_result_t;

endpackage : adcw_pkg

`default_nettype wire

// file: adcw_sync.sv
// Purpose: Two-stage synchroniser for a group of independent levels.
// Assumes: Each bit is a slowly changing level, not a multi-bit word.
// Notes: Stage one is read only by stage two.
`default_nettype none

module adcw_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_sys, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [WIDTH-1:0] async_in, // Levels from another domain
    output logic [WIDTH-1:0] sync_out // Synchronised levels
);
    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1) begin : g_bad_width
        $error("adcw_sync needs WIDTH of at least one");
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_reg <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // adcw_sync

`default_nettype wire

// file: adcw_temp_avg.sv
// Purpose: Moving average of temperature samples, seven eighths old plus one eighth new.
// Assumes: Samples are 12-bit twos complement, one per valid pulse.
// Notes: Three fraction bits are kept so that small steps are not lost to truncation.
`default_nettype none
`include "adcw_defines.svh"

module adcw_temp_avg #(
    parameter int SHIFT = `ADCW_AVG_SHIFT
) (
    input wire logic clk_sys, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic restart, // Next sample starts a fresh average
    input wire logic avg_on, // Averaging selected
    input wire logic sample_valid, // New sample pulse
    input wire logic [11:0] sample, // Latest temperature sample
    output logic result_valid, // Result pulse
    output logic [11:0] result // Averaged or plain temperature
);
    localparam int ACCW = 12 + SHIFT;
    logic [ACCW-1:0] acc_reg;
    logic [ACCW-1:0] acc_next;
    logic fresh_reg;

    if (SHIFT != 3) begin : g_bad_shift
        $error("adcw_temp_avg weights are fixed at seven eighths");
    end

    always_comb begin
        acc_next = acc_reg - {{SHIFT{acc_reg[ACCW-1]}}, acc_reg[ACCW-1:SHIFT]}
                   + {{SHIFT{sample[11]}}, sample};
        if (fresh_reg || !avg_on) begin
            acc_next = {sample, {SHIFT{1'b0}}};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            acc_reg <= '0;
            fresh_reg <= 1'b1;
        end else if (restart) begin
            fresh_reg <= 1'b1;
        end else if (sample_valid) begin
            acc_reg <= acc_next;
            fresh_reg <= !avg_on;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            result_valid <= 1'b0;
            result <= 12'h000;
        end else begin
            result_valid <= sample_valid;
            if (sample_valid) begin
                result <= avg_on ? acc_next[ACCW-1:SHIFT] : sample;
            end
        end
    end
endmodule // adcw_temp_avg

`default_nettype wire

// file: test_adc_control_word_decoder.sv
// Purpose: Self-checking bench of the configuration word decoder.
// Assumes: Converter answers one cycle after each start; sensor 20 cycles into busy.
// Notes: Each row is one frame: word sent, word read, reference and sleep after it.
`default_nettype none

module test_adc_control_word_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [15:0] w; logic [15:0] r; logic e; logic s;} adcw_row_t;
    logic clk_sys;
    logic sys_rst = 1'h1;
    wire logic sclk;
    wire logic cs_n;
    wire logic din;
    logic dout, conv_start, temp_start, temp_busy, outside_reference_select_sel, partial_sleep;
    logic [2:0] mux_sel;
    logic [11:0] adc_result = 12'h000;
    logic adc_result_valid = 1'h0;
    logic [11:0] temp_result = 12'h190;
    logic temp_done = 1'h0;
    logic [4:0] tcnt = 5'h00;
    logic [15:0] r;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    int n3;
    adcw_row_t rows [22] = '{
        '{16'hA804, 16'hFFFF, 1'h1, 1'h0}, '{16'h0000, 16'hFFFF, 1'h1, 1'h0},
        '{16'h0000, 16'h05A0, 1'h1, 1'h0}, '{16'h0000, 16'h25A2, 1'h1, 1'h0},
        '{16'h7FFF, 16'hFFFF, 1'h1, 1'h0}, '{16'h0000, 16'hFFFF, 1'h1, 1'h0},
        '{16'h8078, 16'hFFFF, 1'h0, 1'h0}, '{16'h0000, 16'hFFFF, 1'h0, 1'h0},
        '{16'h0000, 16'h75A7, 1'h0, 1'h0}, '{16'h0000, 16'h8190, 1'h0, 1'h0},
        '{16'h0000, 16'hFFFF, 1'h0, 1'h0}, '{16'h8022, 16'hFFFF, 1'h0, 1'h0},
        '{16'h0000, 16'hFFFF, 1'h0, 1'h0}, '{16'h8022, 16'h9198, 1'h0, 1'h0},
        '{16'h0000, 16'hFFFF, 1'h0, 1'h0}, '{16'h0000, 16'h9199, 1'h0, 1'h0},
        '{16'h9005, 16'hFFFF, 1'h1, 1'h1}, '{16'h0000, 16'hFFFF, 1'h1, 1'h1},
        '{16'h9000, 16'hFFFF, 1'h0, 1'h0}, '{16'h0000, 16'hFFFF, 1'h0, 1'h0},
        '{16'h0000, 16'h15A1, 1'h0, 1'h0}, '{16'hC600, 16'hFFFF, 1'h0, 1'h0}};

    adcw_control_word_decoder u_adcw_control_word_decoder (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .adc_result(adc_result),
        .adc_result_valid(adc_result_valid), .temp_result(temp_result), .temp_done(temp_done),
        .conv_start(conv_start), .mux_sel(mux_sel), .temp_start(temp_start), .temp_busy(temp_busy),
        .outside_reference_select_sel(outside_reference_select_sel), .partial_sleep(partial_sleep));
    adcw_host u_adcw_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Converter data carries the channel so a wrong tag or channel shows at dout
    always @(negedge clk_sys) begin
        adc_result_valid <= conv_start;
        if (conv_start) begin
            adc_result <= 12'h5A0 + {9'h000, mux_sel};
        end
        temp_done <= (tcnt == 5'h14);
        if (temp_done) begin
            temp_result <= temp_result + 12'h008;
        end
        tcnt <= temp_busy ? tcnt + 5'h01 : 5'h00;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %b got %b", nm, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge clk_sys);
        sys_rst = 1'h0;
        @(negedge clk_sys);
        chk1("outside_reference_select_sel", 1'h0, outside_reference_select_sel);
        chk1("partial_sleep", 1'h0, partial_sleep);
        foreach (rows[i]) begin
            u_adcw_host.frame(rows[i].w, 16, r);
            chk16("dout word", rows[i].r, r);
            chk1("outside_reference_select_sel", rows[i].e, outside_reference_select_sel);
            chk1("partial_sleep", rows[i].s, partial_sleep);
        end
        n3 = 0;
        repeat (6) begin
            u_adcw_host.frame(16'h0000, 16, r);
            if (r === 16'h35A3) begin
                n3++;
            end
        end
        chk1("repeat rerun", 1'h1, n3 >= 2);
        // Extra edges carry ones: a decoder taking the last 16 bits would drop the write
        u_adcw_host.frame(16'h8004, 20, r);
        chk1("outside_reference_select_sel", 1'h1, outside_reference_select_sel);
        // Mid-run reset with a result already queued: queue and configuration must clear
        @(negedge clk_sys);
        sys_rst = 1'h1;
        repeat (8) @(negedge clk_sys);
        sys_rst = 1'h0;
        @(negedge clk_sys);
        chk1("outside_reference_select_sel", 1'h0, outside_reference_select_sel);
        chk1("partial_sleep", 1'h0, partial_sleep);
        chk1("temp_busy", 1'h0, temp_busy);
        u_adcw_host.frame(16'hFFFF, 12, r);
        chk16("dout after reset", 16'hFFFF, r);
        chk1("partial_sleep", 1'h0, partial_sleep);
        // Averaging bit without a temperature request: no temperature result may appear
        u_adcw_host.frame(16'h8002, 16, r);
        u_adcw_host.frame(16'h0000, 16, r);
        u_adcw_host.frame(16'h0000, 16, r);
        chk16("dout word", 16'hFFFF, r);
        end_of_test();
    end
endmodule // test_adc_control_word_decoder

`default_nettype wire
